// File: core/coulomb_defines.svh
// Constants shared by the charge-counter flag logic
`ifndef COULOMB_DEFINES_SVH
`define COULOMB_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------
`define SYS_CLK_MHZ           40
`define CLEAR_MIN_US          20
`define FLAG_LOW_MIN_US       1
`define INIT_MIN_US           5000
`define SETTLE_MAX_US         80000
`define INTEG_FULL_US         600
`define SERVICE_MAX_US        500000

// Transfer figures for a test model of the analog side
`define VF_GAIN_MILLIHZ_PER_V 32550
`define COUNT_DIVIDE          1024

// ----------------------------------------------------------------
// Cycle counts derived from the times above
// ----------------------------------------------------------------
// Clear must be held strictly longer than its minimum
`define CLEAR_CYCLES          (`CLEAR_MIN_US * `SYS_CLK_MHZ + 1)
`define FLAG_LOW_CYCLES       (`FLAG_LOW_MIN_US * `SYS_CLK_MHZ)
`define INIT_CYCLES           (`INIT_MIN_US * `SYS_CLK_MHZ)
`define SETTLE_CYCLES         (`SETTLE_MAX_US * `SYS_CLK_MHZ)
`define INTEG_FULL_CYCLES     (`INTEG_FULL_US * `SYS_CLK_MHZ)

// ----------------------------------------------------------------
// Bit positions in the synchronised pin vector
// ----------------------------------------------------------------
`define PIN_COUNT             6
`define PIN_POWER_DOWN_N      0
`define PIN_SUPPLY_OK         1
`define PIN_FLAG_CLEAR_N      2
`define PIN_RAMP_UPPER        3
`define PIN_RAMP_LOWER        4
`define PIN_RAMP_RISING       5

`endif

// File: core/coulomb_pkg.sv
// Types shared by the charge-counter flag logic
package coulomb_pkg;

    // Operating state of the counting core
    typedef enum logic [1:0] {
        state_off,
        state_init,
        state_run
    } count_state_type;

endpackage : coulomb_pkg

// File: core/pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_reg;

    // Two flip-flops per pin
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pin_sync

// File: core/hold_timer.sv
// Saturating hold timer: done once run has stood for CYCLES clocks
`timescale 1ns/1ps
module hold_timer #(
    parameter int CYCLES = 40,
    parameter int WIDTH  = $clog2(CYCLES + 1)
) (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic run_in,
    output logic      done_out
);

    // Terminal count at the counter width
    localparam logic [WIDTH-1:0] LAST = WIDTH'(CYCLES);

    logic [WIDTH-1:0] count_reg;   // Cycles that run has stood

    // Count while run is high, restart when it drops, hold at the end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg <= '0;
        end else if (!run_in) begin
            count_reg <= '0;
        end else if (count_reg != LAST) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Done stands as long as run keeps standing
    assign done_out = (count_reg == LAST);

endmodule : hold_timer

// File: core/coulomb_counter_flag_logic.sv
// Digital core of a charge counter: ramp steering, unit counter, flag and direction latch
//
// Notes on behaviour
// - Power-down low resets all counting state
// - Idle flag: direction follows latest current polarity
// - Flag assertion freezes direction at unit polarity
// - Power-down releases both open-drain outputs
// - Clear held over 20us releases flag
// - Counting continues while flag or clear low
// - Wired clear: flag stays low at least 1us
// - One flag per charge unit counted while the flag is released
// - Test model gain is 32.55 Hz per volt
// - Power-on resets; counting waits 5ms initialisation
// - Counts may be inaccurate for further 80ms
// - Undervoltage below 2.5V resets all state
// - Power-down release repeats the initialisation interval
// - Thresholds reverse ramp; switches give polarity
// - Integration interval 600us at full scale
// - Up/down counter divides reversals by 1024
// - Valid clear also unlatches direction output
// - Unit completing while flag latched is lost, unless a valid clear fires in that cycle
`timescale 1ns/1ps
`include "coulomb_defines.svh"
module coulomb_counter_flag_logic #(
    parameter int INIT_CYCLES   = `INIT_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter int COUNT_DIVIDE  = `COUNT_DIVIDE
) (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic power_down_n_in,
    input  wire logic supply_ok_in,
    input  wire logic flag_clear_n_in,
    input  wire logic ramp_upper_threshold_in,
    input  wire logic ramp_lower_threshold_in,
    input  wire logic ramp_rising_in,
    output logic      ramp_switch_a_out,
    output logic      ramp_switch_b_out,
    output logic      flag_n_out,
    output logic      flag_n_oe_out,
    output logic      current_direction_out,
    output logic      current_direction_oe_out,
    output logic      powered_down_out,
    output logic      counting_out,
    output logic      tracking_settled_out
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------
    localparam int             CW        = $clog2(COUNT_DIVIDE);
    localparam logic [CW-1:0]  CNT_MAX   = CW'(COUNT_DIVIDE - 1);
    localparam logic [CW-1:0]  CNT_START = CW'(COUNT_DIVIDE / 2);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [`PIN_COUNT-1:0]       pins_raw;          // Raw pin vector
    logic [`PIN_COUNT-1:0]       pins_sync;         // Pins after two flops
    logic                        power_down_n;      // Synced power-down
    logic                        supply_ok;         // Synced supply monitor
    logic                        flag_clear_n;      // Synced clear
    logic                        ramp_upper;        // Synced upper comparator
    logic                        ramp_lower;        // Synced lower comparator
    logic                        ramp_rising;       // Synced ramp slope
    logic                        hold_reset;        // Power-down or undervoltage
    coulomb_pkg::count_state_type state_reg;        // Operating state
    logic                        init_done;         // Init interval elapsed
    logic                        settle_done;       // Tracking settle elapsed
    logic                        ramp_hit;          // Ramp at a threshold
    logic                        hit_prev_reg;      // Previous ramp_hit
    logic                        reversal;          // One-cycle ramp reversal
    logic                        switch_sel_reg;    // Steering switch state
    logic                        charging_now;      // Polarity of this reversal
    logic                        live_charging_reg; // Latest live polarity
    logic [CW-1:0]               count_reg;         // Up/down unit counter
    logic                        unit_event;        // Counter over/underflow
    logic                        flag_reg;          // Charge-unit flag latched
    logic                        dir_latched_reg;   // Frozen unit polarity
    logic                        clear_armed_reg;   // Clear seen high since last use
    logic                        clear_done;        // Clear held long enough
    logic                        flag_age_done;     // Flag held its minimum
    logic                        clear_fire;        // Valid clear this cycle
    logic                        flag_take;         // Flag set this cycle
    logic                        running;           // Core in counting state

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    assign pins_raw = {ramp_rising_in, ramp_lower_threshold_in,
                       ramp_upper_threshold_in, flag_clear_n_in,
                       supply_ok_in, power_down_n_in};

    // All external levels pass two flops before use
    pin_sync #(
        .WIDTH (`PIN_COUNT)
    ) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .pin_in     (pins_raw),
        .sync_out   (pins_sync)
    );

    assign power_down_n = pins_sync[`PIN_POWER_DOWN_N];
    assign supply_ok    = pins_sync[`PIN_SUPPLY_OK];
    assign flag_clear_n = pins_sync[`PIN_FLAG_CLEAR_N];
    assign ramp_upper   = pins_sync[`PIN_RAMP_UPPER];
    assign ramp_lower   = pins_sync[`PIN_RAMP_LOWER];
    assign ramp_rising  = pins_sync[`PIN_RAMP_RISING];

    // Either source holds the whole core in reset
    assign hold_reset = !power_down_n || !supply_ok;
    assign running    = (state_reg == coulomb_pkg::state_run);

    // ----------------------------------------------------------------
    // Power and initialisation sequence
    // ----------------------------------------------------------------
    // Every exit from reset passes a full init interval
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= coulomb_pkg::state_off;
        end else if (hold_reset) begin
            state_reg <= coulomb_pkg::state_off;
        end else begin
            case (state_reg)
                // Leaving reset starts a fresh interval
                coulomb_pkg::state_off: begin
                    state_reg <= coulomb_pkg::state_init;
                end
                // Wait out the interval before counting
                coulomb_pkg::state_init: begin
                    if (init_done) begin
                        state_reg <= coulomb_pkg::state_run;
                    end
                end
                coulomb_pkg::state_run: begin
                    state_reg <= coulomb_pkg::state_run;
                end
                default: begin
                    state_reg <= coulomb_pkg::state_off;
                end
            endcase
        end
    end

    // Initialisation interval timer
    hold_timer #(
        .CYCLES (INIT_CYCLES)
    ) u_init_timer (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (state_reg == coulomb_pkg::state_init),
        .done_out   (init_done)
    );

    // Marks the end of the period where counts may be inaccurate
    hold_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle_timer (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (running),
        .done_out   (settle_done)
    );

    // ----------------------------------------------------------------
    // Ramp steering and polarity
    // ----------------------------------------------------------------
    // Threshold reached in the direction the ramp is moving
    assign ramp_hit = (ramp_upper && ramp_rising) ||
                      (ramp_lower && !ramp_rising);
    // Each reversal closes one integration interval
    assign reversal = ramp_hit && !hit_prev_reg && running;
    // Switch state together with slope gives the sense polarity
    assign charging_now = ramp_rising ^ switch_sel_reg;

    // Edge detector on the threshold hit
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hit_prev_reg <= 1'h0;
        end else begin
            hit_prev_reg <= ramp_hit;
        end
    end

    // Swap the steering switches on every reversal
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            switch_sel_reg <= 1'h0;
        end else if (!running) begin
            switch_sel_reg <= 1'h0;
        end else if (reversal) begin
            switch_sel_reg <= !switch_sel_reg;
        end
    end

    // Live polarity, released (charging) while not counting
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            live_charging_reg <= 1'h1;
        end else if (!running) begin
            live_charging_reg <= 1'h1;
        end else if (reversal) begin
            live_charging_reg <= charging_now;
        end
    end

    // ----------------------------------------------------------------
    // Unit counter
    // ----------------------------------------------------------------
    // Wraps on each unit; never stalled by the flag or by clear
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg <= CNT_START;
        end else if (!running || hold_reset) begin
            // Restart in the same edge that stops counting
            count_reg <= CNT_START;
        end else if (reversal && charging_now) begin
            count_reg <= count_reg + 1'b1;
        end else if (reversal) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Overflow counting up or underflow counting down
    assign unit_event = reversal &&
                        (charging_now ? (count_reg == CNT_MAX)
                                      : (count_reg == '0));

    // ----------------------------------------------------------------
    // Clear qualification
    // ----------------------------------------------------------------
    // Clear must go high between uses so one long pulse clears once
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clear_armed_reg <= 1'h0;
        end else if (flag_clear_n) begin
            clear_armed_reg <= 1'h1;
        end else if (clear_fire) begin
            clear_armed_reg <= 1'h0;
        end
    end

    // Minimum clear low width
    hold_timer #(
        .CYCLES (`CLEAR_CYCLES)
    ) u_clear_timer (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (!flag_clear_n && clear_armed_reg && running),
        .done_out   (clear_done)
    );

    // Minimum flag low time, covers the wired-back case
    hold_timer #(
        .CYCLES (`FLAG_LOW_CYCLES)
    ) u_flag_age_timer (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .run_in     (flag_reg),
        .done_out   (flag_age_done)
    );

    assign clear_fire = clear_done && flag_age_done && flag_reg;
    // A unit in the clearing cycle is kept; otherwise one arriving while the flag is latched is dropped
    assign flag_take  = unit_event && (!flag_reg || clear_fire);

    // ----------------------------------------------------------------
    // Flag and direction latch
    // ----------------------------------------------------------------
    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_reg <= 1'h0;
        end else if (!running || hold_reset) begin
            // Released in the same edge that enters the off state
            flag_reg <= 1'h0;
        end else if (flag_take) begin
            flag_reg <= 1'h1;
        end else if (clear_fire) begin
            flag_reg <= 1'h0;
        end
    end

    // Freeze the polarity of the unit just counted
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dir_latched_reg <= 1'h1;
        end else if (!running) begin
            dir_latched_reg <= 1'h1;
        end else if (flag_take) begin
            dir_latched_reg <= charging_now;
        end
    end

    // ----------------------------------------------------------------
    // Open-drain outputs
    // ----------------------------------------------------------------
    // Pins are never driven high, only pulled low or released
    assign flag_n_out            = 1'h0;
    assign current_direction_out = 1'h0;
    // Flag pulls low while latched; released when off
    assign flag_n_oe_out = flag_reg;
    // Pull low for discharge: frozen while latched, live otherwise
    assign current_direction_oe_out = running &&
        (flag_reg ? !dir_latched_reg : !live_charging_reg);

    // Steering switches are complementary, both open when off
    assign ramp_switch_a_out = running && switch_sel_reg;
    assign ramp_switch_b_out = running && !switch_sel_reg;

    // Status levels
    assign powered_down_out     = (state_reg == coulomb_pkg::state_off);
    assign counting_out         = running;
    assign tracking_settled_out = settle_done;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    localparam int CLEAR_N = `CLEAR_CYCLES;
    localparam int AGE_N   = `FLAG_LOW_CYCLES;

    logic [15:0] clear_low_cnt_reg;   // Cycles clear has stood low
    logic [15:0] flag_age_cnt_reg;    // Cycles the flag has stood

    // Helper counters, saturating
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clear_low_cnt_reg <= 16'h0000;
            flag_age_cnt_reg  <= 16'h0000;
        end else begin
            if (flag_clear_n) begin
                clear_low_cnt_reg <= 16'h0000;
            end else if (clear_low_cnt_reg != 16'hFFFF) begin
                clear_low_cnt_reg <= clear_low_cnt_reg + 16'h0001;
            end
            if (!flag_reg) begin
                flag_age_cnt_reg <= 16'h0000;
            end else if (flag_age_cnt_reg != 16'hFFFF) begin
                flag_age_cnt_reg <= flag_age_cnt_reg + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_hold;
        hold_reset;
    endsequence
    sequence s_unit_taken;
        unit_event && !flag_reg && !hold_reset;
    endsequence

    property p_pd_reset;
        !power_down_n |=> !running && count_reg == CNT_START && !flag_reg;
    endproperty
    a_pd_reset: assert property (p_pd_reset)
        else $error("power-down did not reset counting state");

    property p_uv_reset;
        s_hold ##0 !supply_ok |=> powered_down_out && !flag_n_oe_out;
    endproperty
    a_uv_reset: assert property (p_uv_reset)
        else $error("undervoltage did not reset the core");

    property p_off_released;
        powered_down_out |-> !flag_n_oe_out && !current_direction_oe_out;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("output pulled low while powered down");

    property p_resume_init;
        s_hold ##1 !hold_reset |=> state_reg == coulomb_pkg::state_init;
    endproperty
    a_resume_init: assert property (p_resume_init)
        else $error("release of power-down skipped initialisation");

    property p_run_after_init;
        $rose(running) |-> $past(init_done);
    endproperty
    a_run_after_init: assert property (p_run_after_init)
        else $error("counting began before initialisation ended");

    property p_flag_latch;
        s_unit_taken |=> flag_reg && dir_latched_reg == $past(charging_now)
                         && current_direction_oe_out == !$past(charging_now);
    endproperty
    a_flag_latch: assert property (p_flag_latch)
        else $error("unit did not latch flag with its polarity");

    property p_dir_live;
        running && !flag_reg |-> current_direction_oe_out == !live_charging_reg;
    endproperty
    a_dir_live: assert property (p_dir_live)
        else $error("direction not following live polarity");

    property p_clear_width;
        $fell(flag_reg) && running |-> $past(clear_low_cnt_reg) >= CLEAR_N;
    endproperty
    a_clear_width: assert property (p_clear_width)
        else $error("flag released without a long enough clear");

    property p_flag_age;
        $fell(flag_reg) && running |-> $past(flag_age_cnt_reg) >= AGE_N;
    endproperty
    a_flag_age: assert property (p_flag_age)
        else $error("flag released before its minimum low time");

    property p_lost_unit;
        flag_reg && unit_event && !clear_fire && !hold_reset
            |=> $stable(dir_latched_reg) && flag_reg;
    endproperty
    a_lost_unit: assert property (p_lost_unit)
        else $error("unit queued while flag was latched");

    property p_count_runs;
        reversal && charging_now && count_reg != CNT_MAX && !hold_reset
            |=> count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_count_runs: assert property (p_count_runs)
        else $error("counter did not step on a reversal");

endmodule : coulomb_counter_flag_logic

// File: verification/host_service_model.sv
// Host model: services the charge-unit flag with clear pulses
`timescale 1ns/1ps
module host_service_model (
    input  wire logic sys_clk_in,
    input  wire logic flag_pin_in,
    input  wire logic enable_in,
    input  wire logic [31:0] hold_in,
    output logic      flag_clear_n_out
);
    int cnt_reg;  // Cycles of the clear pulse still to go
    initial begin
        cnt_reg          = 0;
        flag_clear_n_out = 1'b1;
    end
    // Pulse clear low once the flag is seen; release when the count runs out
    always @(posedge sys_clk_in) begin
        if (cnt_reg > 0) begin
            cnt_reg          <= cnt_reg - 1;
            flag_clear_n_out <= (cnt_reg == 1);
        end else if (enable_in && !flag_pin_in) begin
            cnt_reg          <= hold_in;
            flag_clear_n_out <= 1'b0;
        end
    end
endmodule : host_service_model

// File: verification/coulomb_counter_flag_logic_test.sv
// Bench for the charge-counter flag logic with a host model
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %b got %b", n, e, g); end end
`define WAITC(c) begin for (k = 0; k < 2000 && (c) !== 1'b1; k++) @(posedge sys_clk_in); if ((c) !== 1'b1) begin mismatches++; close_out(); end end
module coulomb_counter_flag_logic_test;
    logic sys_clk_in, nrst_in, power_down_n_in, supply_ok_in, upper, lower, rising, host_en;
    int   hold, k, mismatches, total_checks;
    wire logic clear_n, sw_a, sw_b, flag_drv, dir_drv, flag_oe, dir_oe, off, counting, settled;
    wire logic flag_pin = !flag_oe;  // Pull-up on the open-drain flag line
    coulomb_counter_flag_logic #(.INIT_CYCLES(50), .SETTLE_CYCLES(100)) i_coulomb_counter_flag_logic (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .power_down_n_in(power_down_n_in),
        .supply_ok_in(supply_ok_in), .flag_clear_n_in(clear_n), .ramp_upper_threshold_in(upper),
        .ramp_lower_threshold_in(lower), .ramp_rising_in(rising), .ramp_switch_a_out(sw_a),
        .ramp_switch_b_out(sw_b), .flag_n_out(flag_drv), .flag_n_oe_out(flag_oe), .current_direction_out(dir_drv),
        .current_direction_oe_out(dir_oe), .powered_down_out(off), .counting_out(counting),
        .tracking_settled_out(settled));
    host_service_model i_host_service_model (.sys_clk_in(sys_clk_in), .flag_pin_in(flag_pin),
        .enable_in(host_en), .hold_in(hold), .flag_clear_n_out(clear_n));
    initial begin
        forever #12.5 sys_clk_in = !sys_clk_in;
    end
    // One ramp reversal of polarity current_direction (1 = charging)
    task rev(input logic current_direction);
        rising <= current_direction ^ sw_a;
        upper  <= current_direction ^ sw_a;
        lower  <= !(current_direction ^ sw_a);
        repeat (4) @(posedge sys_clk_in);
        upper <= 1'b0;
        lower <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask : rev
    // Units latch, freeze direction and drop while latched
    task units();
        repeat (513) rev(1'b1);
        `CHK("flag_set", 1'b1, flag_oe)
        `CHK("dir_charge", 1'b0, dir_oe)
        `CHK("sw_swap", 1'b1, sw_a)
        `CHK("sw_pair", 1'b1, sw_a ^ sw_b)
        `CHK("flag_drive", 1'b0, flag_drv)
        `CHK("dir_drive", 1'b0, dir_drv)
        repeat (1100) rev(1'b0);
        `CHK("flag_kept", 1'b1, flag_oe)
        `CHK("dir_frozen", 1'b0, dir_oe)
    endtask : units
    // Short clears ignored, long clear releases, counter kept running
    task clears();
        hold    <= 100;
        host_en <= 1'b1;
        repeat (700) @(posedge sys_clk_in);
        `CHK("short_clear", 1'b1, flag_oe)
        host_en <= 1'b0;
        repeat (120) @(posedge sys_clk_in);
        hold    <= 820;
        host_en <= 1'b1;
        `WAITC(flag_oe === 1'b0)
        host_en <= 1'b0;
        `CHK("dir_live", 1'b1, dir_oe)
        repeat (12) @(posedge sys_clk_in);
        repeat (949) rev(1'b0);
        `CHK("no_unit_yet", 1'b0, flag_oe)
        rev(1'b0);
        `CHK("next_unit", 1'b1, flag_oe)
        `CHK("dir_discharge", 1'b1, dir_oe)
    endtask : clears
    // Power-down or undervoltage, then a fresh start-up
    task drop(input logic sup);
        if (sup) supply_ok_in <= 1'b0;
        else power_down_n_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        `CHK("off", 1'b1, off)
        `CHK("flag_free", 1'b0, flag_oe)
        `CHK("dir_free", 1'b0, dir_oe)
        `CHK("sw_open", 1'b0, sw_a | sw_b)
        supply_ok_in    <= 1'b1;
        power_down_n_in <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        `CHK("init_wait", 1'b0, counting)
        `WAITC(counting === 1'b1)
        `CHK("not_settled", 1'b0, settled)
        `WAITC(settled === 1'b1)
    endtask : drop
    task close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    initial begin
        sys_clk_in = 0; nrst_in = 0; power_down_n_in = 1; supply_ok_in = 1;
        upper = 0; lower = 0; rising = 0; host_en = 0; hold = 820; mismatches = 0; total_checks = 0;
        repeat (12) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        `CHK("reset_flag", 1'b0, flag_oe)
        `CHK("reset_idle", 1'b0, counting)
        `WAITC(counting === 1'b1)
        units();
        clears();
        drop(1'b0);
        drop(1'b1);
        close_out();
    end
endmodule : coulomb_counter_flag_logic_test
